// ===== rtl/buck_regs_pkg.sv
// Purpose: Shared constants and types for the converter-one register bank
// Assumes: 8-bit registers, 8-bit register pointer
// Notes: Reset values are the values shown before the NVM copy lands
package buck_regs_pkg;
  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] OFS_IDENTITY = 8'h01;
  localparam logic [7:0] OFS_NVM_VERSION = 8'h02;
  localparam logic [7:0] OFS_NVM_REVISION = 8'h03;
  localparam logic [7:0] OFS_CONV1_CTRL = 8'h04;
  localparam logic [7:0] OFS_CONV1_CONF = 8'h05;

  // ---------------------------------------------
  // Reset values and reserved masks
  // ---------------------------------------------
  localparam logic [7:0] RST_IDENTITY = 8'h00;
  localparam logic [7:0] RST_NVM_CODE = 8'h00;
  localparam logic [7:0] RST_CONV1_CTRL = 8'h22;
  localparam logic [7:0] RST_CONV1_CONF = 8'h22;
  localparam logic [7:0] RSV_CONV1_CTRL = 8'h44;
  localparam logic [7:0] RSV_CONV1_CONF = 8'hc0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ---------------------------------------------
  // Control field positions
  // ---------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_FPWM_BIT = 1;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_MON_BIT = 4;
  localparam int CTRL_PLDN_BIT = 5;
  localparam int CTRL_RV_BIT = 7;

  // ---------------------------------------------
  // Serial target constants
  // ---------------------------------------------
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h48; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Control register layout, msb first
  typedef struct packed {
    logic residual_check;
    logic rsv6;
    logic discharge_on;
    logic monitor_on;
    logic setpoint_choice;
    logic rsv2;
    logic forced_fixed_freq;
    logic on;
  } ctrl_t;

  // Register write strobe with its data
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // NVM image copied in after reset
  typedef struct packed {
    logic [7:0] identity;
    logic [7:0] version;
    logic [7:0] revision;
    logic [7:0] ctrl;
    logic [7:0] conf;
  } nvm_image_t;
endpackage : buck_regs_pkg

// ===== rtl/pin_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to sys_clk
// Notes: A change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ---------------------------------------------
  // Sync chain, idles high like a pulled-up bus
  // ---------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else if (ce) begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Filtered level only moves on agreement
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level <= 1'b1;
    end else if (ce && (s2_r == s3_r)) begin
      level <= s3_r;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// ===== rtl/conv_one_drive.sv
// Purpose: Turns the control register into converter-one drive levels
// Assumes: Setpoint codes arrive from the rest of the map
// Notes: All outputs registered, one edge after the register
`timescale 1ns/10ps
`default_nettype none
module conv_one_drive
  import buck_regs_pkg::*;
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Settings
  input wire buck_regs_pkg::ctrl_t ctrl,
  input wire logic [7:0] setpoint_a,
  input wire logic [7:0] setpoint_b,
  // Drive levels
  output logic conv_on,
  output logic forced_fixed_freq,
  output logic [7:0] setpoint,
  output logic monitor_on,
  output logic discharge_on,
  output logic residual_check
);
  // ---------------------------------------------
  // Drive decode
  // ---------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv_on <= 1'b0;
      forced_fixed_freq <= 1'b1;
      setpoint <= 8'h00;
      monitor_on <= 1'b0;
      discharge_on <= 1'b0;
      residual_check <= 1'b0;
    end else if (ce) begin
      conv_on <= ctrl.on;
      // Low selects mixed pulse_frequency_operation and PWM
      forced_fixed_freq <= ctrl.forced_fixed_freq;
      setpoint <= ctrl.setpoint_choice ? setpoint_b : setpoint_a;
      // One enable gates all four comparators together
      monitor_on <= ctrl.monitor_on;
      // Pull-down only while off, never fighting the switcher
      discharge_on <= ctrl.discharge_on & ~ctrl.on;
      residual_check <= ctrl.residual_check;
    end
  end
endmodule : conv_one_drive
`default_nettype wire

// ===== rtl/buck_control_register_bank.sv
// Purpose: Serial-reachable register bank for converter one
// Assumes: I2C target with 8-bit pointer, auto-increment
// Notes: NVM image is copied on the first enabled edge after reset
//
// Overview of operation
// - Control register at 0x4, reset 0x22, fields then copied from NVM.
// - Configuration register at 0x5, reset 0x22.
// - Control bit 0 switches converter one on when set; resets to 0.
// - Control bit 1 forces fixed-frequency PWM when set; resets to 1.
// - Control bit 3 picks setpoint b when set, setpoint a when clear.
// - Control bit 4 enables all four fault comparators; resets to 0.
// - Control bit 5 connects discharge resistor while converter off; resets 1.
// - Control bit 7 enables residual voltage check on feedback; resets 0.
// - NVM version field loads from NVM and ignores host writes.
// - NVM revision field at 0x3 loads from NVM, read-only to host.
// - Host keeps reserved bits zero; a set reserved bit flags map error.
`timescale 1ns/10ps
`default_nettype none
module buck_control_register_bank
  import buck_regs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = buck_regs_pkg::TARGET_ADDR_DEFAULT
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // NVM image and setpoints
  input wire buck_regs_pkg::nvm_image_t nvm_image,
  input wire logic [7:0] setpoint_a,
  input wire logic [7:0] setpoint_b,
  // Converter one drive
  output logic conv_on,
  output logic forced_fixed_freq,
  output logic [7:0] setpoint,
  output logic monitor_on,
  output logic discharge_on,
  output logic residual_check,
  // Status
  output logic map_error
);
  import buck_regs_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DEVADDR = 5'b00010,
    ST_REGADDR = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_READ = 5'b10000
  } state_t;

  state_t state_r;
  logic scl_f;
  logic sda_f;
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic ack_phase_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  reg_wr_t wr_r;
  logic load_pending_r;
  logic [7:0] identity_r;
  logic [7:0] version_r;
  logic [7:0] revision_r;
  ctrl_t ctrl_r;
  logic [7:0] conf_r;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_byte;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Reserved bits of a writable register
  function automatic logic [7:0] rsv_mask(input logic [7:0] addr);
    case (addr)
      OFS_CONV1_CTRL: rsv_mask = RSV_CONV1_CTRL;
      OFS_CONV1_CONF: rsv_mask = RSV_CONV1_CONF;
      default: rsv_mask = 8'h00;
    endcase
  endfunction : rsv_mask

  // Read mux; unmapped offsets answer zero
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    case (addr)
      OFS_IDENTITY: read_reg = identity_r;
      OFS_NVM_VERSION: read_reg = version_r;
      OFS_NVM_REVISION: read_reg = revision_r;
      OFS_CONV1_CTRL: read_reg = ctrl_r;
      OFS_CONV1_CONF: read_reg = conf_r;
      default: read_reg = RD_UNMAPPED;
    endcase
  endfunction : read_reg

  // ---------------------------------------------
  // Pin conditioning
  // ---------------------------------------------
  pin_sync3 u_scl_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pin(scl_in),
    .level(scl_f)
  );

  pin_sync3 u_sda_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pin(sda_in),
    .level(sda_f)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce) begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // Bus conditions, all on filtered levels
  assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign rd_byte = read_reg(ptr_r);

  // ---------------------------------------------
  // Serial target protocol
  // ---------------------------------------------
  // Data changes only on SCL low, so SDA is driven on falls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      sda_oe <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        state_r <= ST_DEVADDR; // Repeated start keeps the pointer
        bit_cnt_r <= 4'h0;
        ack_phase_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_phase_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise && state_r != ST_IDLE) begin
        if (!ack_phase_r) begin
          rx_r <= {rx_r[6:0], sda_f};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (state_r == ST_READ && !sda_oe) begin
          // Master ACK asks for the next byte, NACK ends the read; our own address ACK is not the master's
          if (sda_f) begin
            state_r <= ST_IDLE;
          end else begin
            ptr_r <= ptr_r + 8'h01;
          end
        end
      end else if (scl_fall && state_r != ST_IDLE) begin
        if (ack_phase_r) begin
          ack_phase_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          if (state_r == ST_READ) begin
            sda_oe <= ~rd_byte[7];
            tx_r <= {rd_byte[6:0], 1'b0};
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt_r == BITS_PER_BYTE) begin
          ack_phase_r <= 1'b1;
          case (state_r)
            ST_DEVADDR: begin
              if (rx_r[7:1] == TARGET_ADDR) begin
                sda_oe <= 1'b1;
                state_r <= rx_r[0] ? ST_READ : ST_REGADDR;
              end else begin
                sda_oe <= 1'b0;
                state_r <= ST_IDLE;
              end
            end
            ST_REGADDR: begin
              sda_oe <= 1'b1;
              ptr_r <= rx_r;
              state_r <= ST_WRITE;
            end
            ST_WRITE: begin
              sda_oe <= 1'b1;
              ptr_r <= ptr_r + 8'h01;
            end
            ST_READ: begin
              sda_oe <= 1'b0; // Release for the master's answer
            end
            default: begin
              sda_oe <= 1'b0;
              state_r <= ST_IDLE;
            end
          endcase
        end else if (state_r == ST_READ) begin
          sda_oe <= ~tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Write strobe, one cycle, at the byte's ACK slot
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_r <= '0;
    end else if (ce) begin
      wr_r.en <= scl_fall && !ack_phase_r && state_r == ST_WRITE && bit_cnt_r == BITS_PER_BYTE;
      wr_r.addr <= ptr_r;
      wr_r.data <= rx_r;
    end
  end

  // Open-drain: the pin is only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Register file
  // ---------------------------------------------
  // NVM copy runs once after reset release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_pending_r <= 1'b1;
    end else if (ce) begin
      load_pending_r <= 1'b0;
    end
  end

  // Identification codes, host cannot alter the NVM pair
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      identity_r <= RST_IDENTITY;
      version_r <= RST_NVM_CODE;
      revision_r <= RST_NVM_CODE;
    end else if (ce) begin
      if (load_pending_r) begin
        identity_r <= nvm_image.identity;
        version_r <= nvm_image.version;
        revision_r <= nvm_image.revision;
      end else if (wr_r.en && wr_r.addr == OFS_IDENTITY) begin
        identity_r <= wr_r.data;
      end
    end
  end

  // Converter one control and configuration
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= ctrl_t'(RST_CONV1_CTRL);
      conf_r <= RST_CONV1_CONF;
    end else if (ce) begin
      if (load_pending_r) begin
        ctrl_r <= ctrl_t'(nvm_image.ctrl);
        conf_r <= nvm_image.conf;
      end else if (wr_r.en) begin
        // Whole byte at once so no mixed setting is ever driven
        if (wr_r.addr == OFS_CONV1_CTRL) begin
          ctrl_r <= ctrl_t'(wr_r.data);
        end
        if (wr_r.addr == OFS_CONV1_CONF) begin
          conf_r <= wr_r.data;
        end
      end
    end
  end

  // Integrity flag, sticky until reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      map_error <= 1'b0;
    end else if (ce && wr_r.en && |(wr_r.data & rsv_mask(wr_r.addr))) begin
      map_error <= 1'b1;
    end
  end

  // ---------------------------------------------
  // Converter drive
  // ---------------------------------------------
  conv_one_drive u_drive (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .ctrl(ctrl_r),
    .setpoint_a(setpoint_a),
    .setpoint_b(setpoint_b),
    .conv_on(conv_on),
    .forced_fixed_freq(forced_fixed_freq),
    .setpoint(setpoint),
    .monitor_on(monitor_on),
    .discharge_on(discharge_on),
    .residual_check(residual_check)
  );
endmodule : buck_control_register_bank
`default_nettype wire

// ===== bench/i2c_host_model.sv
// Purpose: Host controller model driving the serial bus
// Assumes: Bench resolves SDA with a pull-up
// Notes: Edges move at sys_clk falls, Q cycles apart
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter int Q = 10
) (
  // Clock and wire level
  input wire logic sys_clk,
  input wire logic sda,
  // Driven lines
  output logic scl,
  output logic sda_low
);
  // ---------------------------------------------
  // Bus tasks
  // ---------------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One phase; long phases keep setup and hold far above the pin filter
  task automatic gap();
    repeat (Q) @(negedge sys_clk);
  endtask : gap

  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b1;
    gap();
    scl = 1'b0;
    gap();
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b0;
    gap();
  endtask : stop

  // Nine bits msb first; a 1 releases the line so the device may answer
  task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      gap();
      scl = 1'b1;
      gap();
      rx[i] = sda;
      scl = 1'b0;
      gap();
    end
  endtask : xfer9
endmodule : i2c_host_model
`default_nettype wire

// ===== bench/buck_control_register_bank_properties.sv
// Purpose: Port-level properties of the converter-one register bank
// Assumes: Single clock, synchronous reset
// Notes: Bus-driven changes must land while SCL is low
`timescale 1ns/10ps
`default_nettype none
module buck_control_register_bank_properties (
  // Clock and bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_oe,
  // Setpoints and drive
  input wire logic [7:0] setpoint_a,
  input wire logic [7:0] setpoint_b,
  input wire logic conv_on,
  input wire logic forced_fixed_freq,
  input wire logic [7:0] setpoint,
  input wire logic monitor_on,
  input wire logic discharge_on,
  input wire logic residual_check,
  input wire logic map_error
);
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Saturating age; hides the image copy just after reset
  logic [1:0] since_rst;
  always_ff @(posedge sys_clk) begin
    if (rst) since_rst <= 2'h0;
    else if (since_rst != 2'h3) since_rst <= since_rst + 2'h1;
  end

  sequence ack_hold;
    sda_oe [*8];
  endsequence

  sequence drive_moved;
    $changed(conv_on) || $changed(forced_fixed_freq) || $changed(monitor_on) || $changed(residual_check);
  endsequence

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  a_reset_values: assert property ($fell(rst) |->
    !conv_on && forced_fixed_freq && !monitor_on && !residual_check && !map_error) else $error("reset drive wrong");
  a_discharge_gate: assert property (discharge_on |-> !conv_on) else $error("discharge while on");
  a_setpoint_pick: assert property (since_rst == 2'h3 && $stable(setpoint_a) && $stable(setpoint_b) |->
    setpoint == setpoint_a || setpoint == setpoint_b) else $error("setpoint not a or b");
  a_error_sticky: assert property (map_error |=> map_error) else $error("map error dropped");
  a_error_bus_low: assert property ($rose(map_error) |-> !scl_in) else $error("map error off a write");
  a_ack_held: assert property ($rose(sda_oe) |-> ack_hold) else $error("sda drive too short");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  a_drive_bus_low: assert property (since_rst == 2'h3 ##0 drive_moved |-> !scl_in)
    else $error("drive moved outside a write");
endmodule : buck_control_register_bank_properties
`default_nettype wire

// ===== bench/buck_control_register_bank_bench.sv
// Purpose: Self-checking bench for the converter-one register bank
// Assumes: Host model on the serial pins, fixed image and setpoints
// Notes: Reset drive first, then drive table, awkward cases and a second reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module buck_control_register_bank_bench;
  import buck_regs_pkg::*;
  // Control value beside {on, pwm, setpoint b, monitor, discharge, residual}
  typedef struct packed {
    logic [7:0] val;
    logic [5:0] exp;
  } row_t;
  row_t rows [8] = '{'{8'h01, 6'h20}, '{8'h02, 6'h10}, '{8'h08, 6'h08}, '{8'h10, 6'h04},
                     '{8'h20, 6'h02}, '{8'h21, 6'h20}, '{8'h80, 6'h01}, '{8'hbb, 6'h3d}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_oe, sda_out, map_error;
  logic conv_on, forced_fixed_freq, monitor_on, discharge_on, residual_check;
  logic [7:0] setpoint;
  nvm_image_t nvm = {8'h11, 8'h3c, 8'h5d, 8'h22, 8'h22};
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // Open drain with pull-up; the device's level only counts while it drives
  wire logic sda = !(sda_low || (sda_oe && !sda_out));
  wire logic [5:0] drive = {conv_on, forced_fixed_freq, setpoint == 8'ha5, monitor_on, discharge_on, residual_check};

  // ---------------------------------------------
  // Clock, parts, watchdog
  // ---------------------------------------------
  always #2 sys_clk = ~sys_clk;

  buck_control_register_bank u_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .nvm_image(nvm), .setpoint_a(8'h5a), .setpoint_b(8'ha5), .conv_on(conv_on),
    .forced_fixed_freq(forced_fixed_freq), .setpoint(setpoint), .monitor_on(monitor_on),
    .discharge_on(discharge_on), .residual_check(residual_check), .map_error(map_error));
  i2c_host_model u_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Whole run needs about 35k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    logic [8:0] rx;
    u_host.start();
    u_host.xfer9({dev, 1'b0, 1'b1}, rx);
    `CHK("address ack", dev != TARGET_ADDR_DEFAULT, rx[0])
    u_host.xfer9({ptr, 1'b1}, rx);
    u_host.xfer9({d, 1'b1}, rx);
    u_host.stop();
  endtask : reg_write

  task automatic check_reg(input logic [7:0] ptr, input logic [7:0] e);
    logic [8:0] rx;
    u_host.start();
    u_host.xfer9({TARGET_ADDR_DEFAULT, 1'b0, 1'b1}, rx);
    u_host.xfer9({ptr, 1'b1}, rx);
    u_host.start();
    u_host.xfer9({TARGET_ADDR_DEFAULT, 1'b1, 1'b1}, rx);
    u_host.xfer9({8'hff, 1'b1}, rx);
    u_host.stop();
    `CHK("register", e, rx[8:1])
  endtask : check_reg

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk);
    `CHK("reset drive", 3'b010, {conv_on, forced_fixed_freq, map_error})
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    foreach (rows[k]) begin
      reg_write(TARGET_ADDR_DEFAULT, OFS_CONV1_CTRL, rows[k].val);
      `CHK("drive", rows[k].exp, drive)
      check_reg(OFS_CONV1_CTRL, rows[k].val);
    end
    // Writable identity, fixed codes, unmapped hole
    reg_write(TARGET_ADDR_DEFAULT, OFS_IDENTITY, 8'h77);
    check_reg(OFS_IDENTITY, 8'h77);
    reg_write(TARGET_ADDR_DEFAULT, OFS_NVM_VERSION, 8'ha5);
    check_reg(OFS_NVM_VERSION, 8'h3c);
    reg_write(TARGET_ADDR_DEFAULT, OFS_NVM_REVISION, 8'ha5);
    check_reg(OFS_NVM_REVISION, 8'h5d);
    reg_write(TARGET_ADDR_DEFAULT, OFS_CONV1_CONF, 8'h2d);
    check_reg(OFS_CONV1_CONF, 8'h2d);
    check_reg(8'h07, 8'h00);
    // Foreign address leaves the map alone
    reg_write(7'h49, OFS_CONV1_CTRL, 8'h01);
    check_reg(OFS_CONV1_CTRL, 8'hbb);
    // Reserved bits flag, and the flag sticks
    reg_write(TARGET_ADDR_DEFAULT, OFS_CONV1_CTRL, 8'h44);
    `CHK("map error", 1'b1, map_error)
    reg_write(TARGET_ADDR_DEFAULT, OFS_CONV1_CTRL, 8'h01);
    `CHK("map error held", 1'b1, map_error)
    // Second reset reloads the image
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("map error cleared", 1'b0, map_error)
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    check_reg(OFS_CONV1_CTRL, 8'h22);
    `CHK("image drive", 6'h12, drive)
    `CHK("setpoint a", 8'h5a, setpoint)
    check_reg(OFS_CONV1_CONF, 8'h22);
    check_reg(OFS_IDENTITY, 8'h11);
    report_and_stop();
  end
endmodule : buck_control_register_bank_bench

bind buck_control_register_bank buck_control_register_bank_properties u_props (.sys_clk, .rst, .scl_in,
  .sda_oe, .setpoint_a, .setpoint_b, .conv_on, .forced_fixed_freq, .setpoint, .monitor_on, .discharge_on,
  .residual_check, .map_error);
`default_nettype wire
